//--- shared/pom_consts.svh
/*
  Constants of the pulse output modulator: widths, carrier rates, the
  linear map format and the input filter time.
  Assumes nothing; it is included by the package and design files.
*/
`ifndef POM_CONSTS_SVH
`define POM_CONSTS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define POM_RES_W 24
`define POM_NRES 8
`define POM_SEL_W 3
`define POM_CODE_W 10
`define POM_NBITS_W 4
`define POM_SLOPE_W 24
`define POM_SLOPE_FRAC 16
`define POM_OFS_W 24
`define POM_PROD_W 49

// ----------------------------------------------------------------
// Clock and carriers, in kHz
// ----------------------------------------------------------------
`define POM_CLK_KHZ 14'd10000
`define POM_CAR_8M_KHZ 14'd8000
`define POM_CAR_1M_KHZ 14'd1000
`define POM_CAR_100K_KHZ 14'd100
`define POM_ACC_W 14
`define POM_CAR_SEL_8M 2'h0
`define POM_CAR_SEL_1M 2'h1
`define POM_CAR_SEL_100K 2'h2

// ----------------------------------------------------------------
// Resolution codes and reset values
// ----------------------------------------------------------------
`define POM_RESN_10 2'h0
`define POM_RESN_9 2'h1
`define POM_RESN_8 2'h2
`define POM_RESN_7 2'h3
`define POM_CODE_RST 10'h000

// ----------------------------------------------------------------
// Input filter: time in ns, cycles rounded up
// ----------------------------------------------------------------
`define POM_CLK_NS 100
`define POM_DEB_NS 10000
`define POM_DEB_CYC ((`POM_DEB_NS + `POM_CLK_NS - 1) / `POM_CLK_NS)
`define POM_DEB_W 7

`endif

//--- shared/pom_pkg.sv
/*
  Types of the pulse output modulator.
  Assumes the constants header is on the include path.
*/
`include "pom_consts.svh"

package pom_pkg;
  typedef logic [`POM_NRES-1:0][`POM_RES_W-1:0] pom_res_arr_t;
  typedef enum logic [1:0] {
    POM_CAR_8M = `POM_CAR_SEL_8M,
    POM_CAR_1M = `POM_CAR_SEL_1M,
    POM_CAR_100K = `POM_CAR_SEL_100K
  } pom_car_t;
  typedef logic [1:0] pom_resn_t;
  typedef logic [`POM_CODE_W-1:0] pom_code_t;
endpackage

//--- shared/pom_chan_if.sv
/*
  Link between the channel front end and one modulator.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/10ps
`include "pom_consts.svh"

interface pom_chan_if;
  logic [`POM_CODE_W-1:0] code;
  logic [`POM_NBITS_W-1:0] nbits;
  logic pdm;
  logic tick;
  logic pulse;
  modport gen (output code, nbits, pdm, tick, input pulse);
  modport mod (input code, nbits, pdm, tick, output pulse);
endinterface

//--- design/pom_mod.sv
/*
  One modulator: width or density modulation of a code on a carrier.
  Assumes tick is a one-cycle strobe at the carrier rate.
*/
`timescale 1ns/10ps
`include "pom_consts.svh"

module pom_mod (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Channel link
  pom_chan_if.mod ch
);
  import pom_pkg::*;

  logic [`POM_CODE_W-1:0] cnt, next_cnt, code_l, next_code_l, mask;
  logic [`POM_CODE_W:0] acc, next_acc, sum;
  logic out, next_out, wrap, full;

  assign mask = `POM_CODE_W'(10'h3ff >> (`POM_CODE_W - ch.nbits));
  assign wrap = ch.tick && (cnt >= mask);
  assign ch.pulse = out;

  // ----------------------------------------------------------------
  // Period counter, code latch and accumulator
  // ----------------------------------------------------------------
  always_comb begin
    next_cnt = cnt;
    next_code_l = code_l;
    next_acc = acc;
    sum = acc + {1'b0, code_l};
    if (ch.tick) begin
      // Period is 2^nbits carrier cycles
      next_cnt = wrap ? '0 : cnt + 1'b1;
      // Code only taken at a period boundary, so no torn period
      if (wrap)
        next_code_l = ch.code & mask;
      // First-order overflow spreads the ones evenly
      if (ch.pdm)
        next_acc = (sum > {1'b0, mask}) ? sum - {1'b0, mask} - 1'b1 : sum;
    end
    full = (next_code_l == mask);
    // Zero gives 0 %, the top code gives 100 %
    if (next_code_l == '0)
      next_out = 1'b0;
    else if (full)
      next_out = 1'b1;
    else if (ch.pdm)
      next_out = ch.tick ? (sum > {1'b0, mask}) : out;
    else
      next_out = next_cnt < next_code_l;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt <= '0;
      code_l <= `POM_CODE_RST;
      acc <= '0;
      out <= 1'b0;
    end else begin
      cnt <= next_cnt;
      code_l <= next_code_l;
      acc <= next_acc;
      out <= next_out;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_zero_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    code_l == '0 |-> !out) else $error("zero code not low");
  a_full_high: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (code_l == mask && $stable(mask)) |-> out) else $error("top code not high");
  a_period_wrap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wrap |=> cnt == '0) else $error("period did not wrap");
  a_code_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $changed(code_l) |-> $past(wrap)) else $error("code changed mid period");
  a_pwm_shape: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!ch.pdm && $stable(ch.pdm) && code_l != mask) |-> out == (cnt < code_l))
    else $error("width output wrong");
  c_pdm_run: cover property (@(posedge clk_i) ch.pdm && out ##1 !out);
  c_pwm_wrap: cover property (@(posedge clk_i) !ch.pdm && wrap);
endmodule

//--- design/pom_top.sv
/*
  Two-channel pulse output modulator with port routing and port input
  filters. Results are mapped to codes, which modulate carrier strobes.
  Assumes all inputs are synchronous to clk_i and the external RC
  filter sits on whichever port carries a pulse.
*/
//
// Contract
// - Each channel emits width or density modulation
// - Source select picks any measurement result
// - Carrier selectable: 8 MHz, 1 MHz, 100 kHz
// - Resolution setting; 10 bits spans 0..1023
// - Code equals slope times result plus offset
// - Slope and offset are signed
// - Out-of-range values clamp to range limits
// - Zero is always low, maximum always high
// - Channel a: port 0/2; b: port 1/3
// - SPI mode blocks pulses on ports 0, 1
// - Input ports: optional debounce and pull-up
// - Select pin low means SPI owns ports 0, 1
`timescale 1ns/10ps
`include "pom_consts.svh"

module pom_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Measurement results
  input wire pom_pkg::pom_res_arr_t results_i,
  // Channel a setup
  input wire logic [`POM_SEL_W-1:0] chan_a_source_sel_i,
  input wire pom_pkg::pom_car_t chan_a_carrier_sel_i,
  input wire pom_pkg::pom_resn_t chan_a_resolution_i,
  input wire logic chan_a_pdm_i,
  input wire logic signed [`POM_SLOPE_W-1:0] chan_a_slope_i,
  input wire logic signed [`POM_OFS_W-1:0] chan_a_offset_i,
  input wire logic chan_a_alt_port_i,
  // Channel b setup
  input wire logic [`POM_SEL_W-1:0] chan_b_source_sel_i,
  input wire pom_pkg::pom_car_t chan_b_carrier_sel_i,
  input wire pom_pkg::pom_resn_t chan_b_resolution_i,
  input wire logic chan_b_pdm_i,
  input wire logic signed [`POM_SLOPE_W-1:0] chan_b_slope_i,
  input wire logic signed [`POM_OFS_W-1:0] chan_b_offset_i,
  input wire logic chan_b_alt_port_i,
  // Port setup
  input wire logic interface_select_pin_i,
  input wire logic [3:0] port_direction_bits_i,
  input wire logic [3:0] pullup_en_i,
  input wire logic [3:0] debounce_en_i,
  // Port pins
  input wire logic gp_port_zero_in_i,
  input wire logic gp_port_one_in_i,
  input wire logic gp_port_two_in_i,
  input wire logic gp_port_three_in_i,
  output logic gp_port_zero_out_o,
  output logic gp_port_one_out_o,
  output logic gp_port_two_out_o,
  output logic gp_port_three_out_o,
  output logic gp_port_zero_oe_o,
  output logic gp_port_one_oe_o,
  output logic gp_port_two_oe_o,
  output logic gp_port_three_oe_o,
  output logic [3:0] pullup_on_o,
  // Filtered port inputs
  output logic [3:0] port_in_filt_o,
  // Channel state
  output logic modulated_out_a_o,
  output logic modulated_out_b_o,
  output pom_pkg::pom_code_t chan_a_code_o,
  output pom_pkg::pom_code_t chan_b_code_o
);
  import pom_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [`POM_NBITS_W-1:0] res_bits(pom_resn_t r);
    case (r)
      `POM_RESN_10: res_bits = 4'ha;
      `POM_RESN_9: res_bits = 4'h9;
      `POM_RESN_8: res_bits = 4'h8;
      default: res_bits = 4'h7;
    endcase
  endfunction

  function automatic logic [`POM_ACC_W-1:0] car_inc(pom_car_t c);
    case (c)
      POM_CAR_8M: car_inc = `POM_CAR_8M_KHZ;
      POM_CAR_1M: car_inc = `POM_CAR_1M_KHZ;
      default: car_inc = `POM_CAR_100K_KHZ;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Per-channel settings gathered into arrays
  // ----------------------------------------------------------------
  logic [1:0][`POM_SEL_W-1:0] src;
  pom_car_t [1:0] car;
  pom_resn_t [1:0] resn;
  logic [1:0] pdm, pulse;
  logic signed [1:0][`POM_SLOPE_W-1:0] slope;
  logic signed [1:0][`POM_OFS_W-1:0] ofs;
  pom_code_t [1:0] code;

  assign src = {chan_b_source_sel_i, chan_a_source_sel_i};
  assign car[0] = chan_a_carrier_sel_i;
  assign car[1] = chan_b_carrier_sel_i;
  assign resn = {chan_b_resolution_i, chan_a_resolution_i};
  assign pdm = {chan_b_pdm_i, chan_a_pdm_i};
  assign slope = {chan_b_slope_i, chan_a_slope_i};
  assign ofs = {chan_b_offset_i, chan_a_offset_i};
  assign chan_a_code_o = code[0];
  assign chan_b_code_o = code[1];
  assign modulated_out_a_o = pulse[0];
  assign modulated_out_b_o = pulse[1];

  // ----------------------------------------------------------------
  // Channels: linear map, clamp, carrier strobe, modulator
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_chan
      pom_chan_if ch ();
      logic signed [`POM_PROD_W-1:0] prod, lin;
      logic [`POM_CODE_W-1:0] mask, next_code;
      logic [`POM_ACC_W-1:0] acc, next_acc, inc;
      logic [`POM_ACC_W:0] sum;
      logic tick, next_tick;

      assign mask = `POM_CODE_W'(10'h3ff >> (4'ha - res_bits(resn[g])));
      // Result is unsigned, slope and offset signed
      // Element selects of a packed array drop the sign, hence the casts
      assign prod = $signed({1'b0, results_i[src[g]]})
                    * $signed(slope[g]);
      // Slope carries fraction bits; floor after the shift
      assign lin = (prod >>> `POM_SLOPE_FRAC)
                   + `POM_PROD_W'($signed(ofs[g]));

      always_comb begin
        // Out-of-range values pin to the limits
        if (lin < 0)
          next_code = '0;
        else if (lin > $signed({39'h0, mask}))
          next_code = mask;
        else
          next_code = lin[`POM_CODE_W-1:0];
        // Fractional divider gives the mean carrier rate
        inc = car_inc(car[g]);
        sum = {1'b0, acc} + {1'b0, inc};
        if (sum >= {1'b0, `POM_CLK_KHZ}) begin
          next_acc = `POM_ACC_W'(sum - {1'b0, `POM_CLK_KHZ});
          next_tick = 1'b1;
        end else begin
          next_acc = sum[`POM_ACC_W-1:0];
          next_tick = 1'b0;
        end
      end

      always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
          code[g] <= `POM_CODE_RST;
          acc <= '0;
          tick <= 1'b0;
        end else begin
          code[g] <= next_code;
          acc <= next_acc;
          tick <= next_tick;
        end
      end

      assign ch.code = code[g];
      assign ch.nbits = res_bits(resn[g]);
      assign ch.pdm = pdm[g];
      assign ch.tick = tick;
      assign pulse[g] = ch.pulse;

      pom_mod u_mod (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ch(ch)
      );

      a_code_range: assert property (@(posedge clk_i)
        disable iff (!rst_b_i)
        $stable(resn[g]) |-> code[g] <= mask)
        else $error("code above range");
      a_neg_clamp: assert property (@(posedge clk_i)
        disable iff (!rst_b_i)
        lin < 0 |=> code[g] == '0)
        else $error("negative value not clamped");
      a_slow_gap: assert property (@(posedge clk_i)
        disable iff (!rst_b_i)
        (tick && car[g] == POM_CAR_100K) ##1 car[g] == POM_CAR_100K
        |-> !tick [*8])
        else $error("slow carrier too fast");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Port routing; SPI mode owns ports 0 and 1
  // ----------------------------------------------------------------
  logic [3:0] pout, poe, next_pout, next_poe;
  logic spi_mode;

  assign spi_mode = !interface_select_pin_i;

  always_comb begin
    // Channel a on port 0 or 2, b on port 1 or 3
    next_pout = {pulse[1] & chan_b_alt_port_i,
                 pulse[0] & chan_a_alt_port_i,
                 pulse[1] & !chan_b_alt_port_i,
                 pulse[0] & !chan_a_alt_port_i};
    next_poe = {chan_b_alt_port_i, chan_a_alt_port_i,
                !chan_b_alt_port_i, !chan_a_alt_port_i};
    // Drive only ports set as outputs
    next_poe = next_poe & ~port_direction_bits_i;
    if (spi_mode)
      next_poe[1:0] = 2'h0;
    next_pout = next_pout & next_poe;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pout <= 4'h0;
      poe <= 4'h0;
    end else begin
      pout <= next_pout;
      poe <= next_poe;
    end
  end

  assign {gp_port_three_out_o, gp_port_two_out_o,
          gp_port_one_out_o, gp_port_zero_out_o} = pout;
  assign {gp_port_three_oe_o, gp_port_two_oe_o,
          gp_port_one_oe_o, gp_port_zero_oe_o} = poe;

  // ----------------------------------------------------------------
  // Input filters and pull-ups
  // ----------------------------------------------------------------
  logic [3:0] raw, filt, next_filt;
  logic [3:0][`POM_DEB_W-1:0] dcnt, next_dcnt;

  assign raw = {gp_port_three_in_i, gp_port_two_in_i,
                gp_port_one_in_i, gp_port_zero_in_i};
  assign port_in_filt_o = filt;
  // Pull-up only when the port is an input
  assign pullup_on_o = pullup_en_i & port_direction_bits_i;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_filt[i] = filt[i];
      next_dcnt[i] = '0;
      // Level must hold for the whole filter time
      if (!debounce_en_i[i])
        next_filt[i] = raw[i];
      else if (raw[i] != filt[i]) begin
        if (dcnt[i] == `POM_DEB_W'(`POM_DEB_CYC - 1))
          next_filt[i] = raw[i];
        else
          next_dcnt[i] = dcnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      filt <= 4'h0;
      dcnt <= '0;
    end else begin
      filt <= next_filt;
      dcnt <= next_dcnt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_spi_block: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    spi_mode |=> !gp_port_zero_oe_o && !gp_port_one_oe_o)
    else $error("SPI port driven");
  a_dir_block: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    port_direction_bits_i[2] |=> !gp_port_two_oe_o)
    else $error("input port driven");
  a_route_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!spi_mode && !chan_a_alt_port_i && !port_direction_bits_i[0])
    |=> gp_port_zero_oe_o && gp_port_zero_out_o == $past(pulse[0]))
    else $error("channel a not on port 0");
  a_deb_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (debounce_en_i[3] && $past(debounce_en_i[3]) && $changed(filt[3]))
    |-> $past(dcnt[3]) == `POM_DEB_W'(`POM_DEB_CYC - 1))
    else $error("filter passed a short glitch");
  c_route_b: cover property (@(posedge clk_i)
    gp_port_three_oe_o && gp_port_three_out_o);
  c_filt_edge: cover property (@(posedge clk_i)
    debounce_en_i[0] && $changed(filt[0]));
endmodule

//--- sim/pom_rc_load.sv
/*
  Behavioural RC low-pass load on one port pin.
  Assumes pin and enable come from the modulator's port drive.
*/
`timescale 1ns/10ps

module pom_rc_load (
  // Clock
  input wire logic clk_i,
  // Pin
  input wire logic pin_i,
  input wire logic oe_i,
  // Filtered level, full scale 1024
  output logic [10:0] level_o
);
  int acc = 0;

  // ----------------------------------------------------------------
  // First-order filter, time constant 256 cycles
  // ----------------------------------------------------------------
  // A released pin leaves the capacitor holding its charge
  always @(posedge clk_i) begin
    if (oe_i === 1'b1) begin
      acc <= acc + ((pin_i === 1'b1 ? 262144 : 0) - acc) / 256;
    end
  end

  assign level_o = 11'(acc / 256);
endmodule

//--- sim/tb_pulse_output_modulator.sv
/*
  Self-checking bench of the two-channel pulse output modulator.
  Assumes pom_top, its package and the RC load model are compiled first.
*/
`timescale 1ns/10ps
`include "pom_consts.svh"

module tb_pulse_output_modulator;
  import pom_pkg::*;

  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  pom_res_arr_t results;
  logic [2:0] a_src, b_src;
  pom_car_t a_car, b_car;
  pom_resn_t a_res, b_res;
  logic a_pdm, b_pdm, a_alt, b_alt, if_sel;
  logic signed [23:0] a_slope, a_ofs, b_slope, b_ofs;
  logic [3:0] dir_bits, pu_en, deb_en, pin_in;
  wire logic [3:0] pout, oe, pu_on, filt;
  logic out_a, out_b;
  pom_code_t code_a, code_b;
  logic [10:0] lvl;
  int mismatches, checks, cycles, hi_a, hi_b, run_a;
  int per[3] = '{160, 1280, 12800};
  logic [23:0] tr[6] = '{1000, 100, 100, 5000, 300, 3};
  logic [23:0] tm[6] = '{24'h008000, 24'hff0000, 24'hff0000,
                         24'h010000, 24'h020000, 24'hff8000};
  logic [23:0] tb_[6] = '{24'h00000a, 24'h000258, 24'h000000,
                          24'h000000, 24'hffff9c, 24'h00000a};

  pom_top dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .results_i(results),
    .chan_a_source_sel_i(a_src), .chan_a_carrier_sel_i(a_car),
    .chan_a_resolution_i(a_res), .chan_a_pdm_i(a_pdm),
    .chan_a_slope_i(a_slope), .chan_a_offset_i(a_ofs),
    .chan_a_alt_port_i(a_alt),
    .chan_b_source_sel_i(b_src), .chan_b_carrier_sel_i(b_car),
    .chan_b_resolution_i(b_res), .chan_b_pdm_i(b_pdm),
    .chan_b_slope_i(b_slope), .chan_b_offset_i(b_ofs),
    .chan_b_alt_port_i(b_alt),
    .interface_select_pin_i(if_sel), .port_direction_bits_i(dir_bits),
    .pullup_en_i(pu_en), .debounce_en_i(deb_en),
    .gp_port_zero_in_i(pin_in[0]), .gp_port_one_in_i(pin_in[1]),
    .gp_port_two_in_i(pin_in[2]), .gp_port_three_in_i(pin_in[3]),
    .gp_port_zero_out_o(pout[0]), .gp_port_one_out_o(pout[1]),
    .gp_port_two_out_o(pout[2]), .gp_port_three_out_o(pout[3]),
    .gp_port_zero_oe_o(oe[0]), .gp_port_one_oe_o(oe[1]),
    .gp_port_two_oe_o(oe[2]), .gp_port_three_oe_o(oe[3]),
    .pullup_on_o(pu_on), .port_in_filt_o(filt),
    .modulated_out_a_o(out_a), .modulated_out_b_o(out_b),
    .chan_a_code_o(code_a), .chan_b_code_o(code_b)
  );

  pom_rc_load rc (.clk_i(clk_i), .pin_i(pout[0]), .oe_i(oe[0]),
                  .level_o(lvl));

  always #50 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // High cycles on ports zero and one, longest high run on port zero
  task automatic measure(input int n);
    int run;
    hi_a = 0;
    hi_b = 0;
    run_a = 0;
    run = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      if (pout[0] === 1'b1) begin
        hi_a++;
        run++;
      end else begin
        run = 0;
      end
      if (run > run_a) run_a = run;
      if (pout[1] === 1'b1) hi_b++;
    end
  endtask

  function automatic int exp_code(input logic [23:0] r,
      input logic signed [23:0] m, input logic signed [23:0] b,
      input pom_resn_t rs);
    longint p;
    int mx;
    mx = (1 << (10 - rs)) - 1;
    p = ((longint'($signed({1'b0, r})) * longint'(m)) >>> 16)
        + longint'(b);
    if (p < 0) return 0;
    if (p > mx) return mx;
    return int'(p);
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Whole run takes about 46000 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    results = '0;
    {a_src, b_src, a_res, b_res} = '0;
    a_car = POM_CAR_8M;
    b_car = POM_CAR_8M;
    {a_pdm, b_pdm, a_alt, b_alt} = '0;
    if_sel = 1'b1;
    {a_slope, b_slope} = {24'h010000, 24'h010000};
    {a_ofs, b_ofs} = '0;
    dir_bits = 4'h0;
    {pu_en, deb_en, pin_in} = '0;
    tick(6);
    check("reset_code_a", code_a, 0);
    check("reset_oe", oe, 0);
    rst_b_i = 1'b1;
    for (int k = 0; k < 8; k++) begin
      results[k] = 24'(k * 37 + 5);
    end
    for (int k = 0; k < 8; k++) begin
      a_src = 3'(k);
      b_src = 3'(7 - k);
      tick(2);
      check("src_code_a", code_a, k * 37 + 5);
      check("src_code_b", code_b, (7 - k) * 37 + 5);
    end
    a_src = 3'h0;
    b_src = 3'h7;
    for (int i = 0; i < 6; i++) begin
      for (int r = 0; r < 4; r++) begin
        results[0] = tr[i];
        results[7] = tr[i];
        {a_slope, b_slope} = {tm[i], tm[i]};
        {a_ofs, b_ofs} = {tb_[i], tb_[i]};
        {a_res, b_res} = {2'(r), 2'(r)};
        tick(2);
        check("map_a", code_a, exp_code(tr[i], tm[i], tb_[i], 2'(r)));
        check("map_b", code_b, exp_code(tr[i], tm[i], tb_[i], 2'(r)));
      end
    end
    // Channel a carries 64 of 128, channel b 32 of 128
    results[0] = 24'h000040;
    results[1] = 24'h000020;
    {a_src, b_src} = {3'h0, 3'h1};
    {a_slope, b_slope} = {24'h010000, 24'h010000};
    {a_ofs, b_ofs} = '0;
    {a_res, b_res} = {2'h3, 2'h3};
    for (int c = 0; c < 3; c++) begin
      a_car = pom_car_t'(c);
      b_car = pom_car_t'(c);
      tick(per[c] + 20);
      // Two periods, so one whole high run lies inside the window
      measure(2 * per[c]);
      check("pwm_high_a", hi_a, per[c]);
      check("pwm_high_b", hi_b, per[c] / 2);
      check("pwm_run_a", run_a, per[c] / 2);
    end
    a_car = POM_CAR_1M;
    b_car = POM_CAR_1M;
    {a_pdm, b_pdm} = 2'b11;
    tick(1300);
    measure(1280);
    check("pdm_high_a", hi_a, 640);
    check("pdm_high_b", hi_b, 320);
    check("pdm_run_a", run_a, 10);
    check("rc_mid", (lvl > 11'd452 && lvl < 11'd572), 1);
    {a_pdm, b_pdm} = 2'b00;
    a_car = POM_CAR_8M;
    b_car = POM_CAR_8M;
    {a_slope, b_slope} = '0;
    b_ofs = 24'h00007f;
    tick(200);
    measure(160);
    check("zero_code_low", hi_a, 0);
    check("max_code_high", hi_b, 160);
    check("zero_out_a", out_a, 0);
    check("max_out_b", out_b, 1);
    // Both channels always high, so out follows oe
    a_ofs = 24'h00007f;
    pu_en = 4'hf;
    tick(200);
    for (int i = 0; i < 8; i++) begin
      logic [3:0] e;
      {a_alt, b_alt} = {i[0], i[1]};
      if_sel = ~i[2];
      dir_bits = (i == 7) ? 4'hf : 4'h0;
      e = {i[1], i[0], ~i[1] & ~i[2], ~i[0] & ~i[2]} & ~dir_bits;
      tick(3);
      check("route_oe", oe, e);
      check("route_out", pout, e);
      check("pullup_on", pu_on, dir_bits);
    end
    dir_bits = 4'hc;
    deb_en = 4'h8;
    pin_in = 4'hc;
    tick(1);
    check("filt_plain", filt[2], 1);
    check("filt_deb_early", filt[3], 0);
    tick(98);
    check("filt_deb_hold", filt[3], 0);
    tick(1);
    check("filt_deb_late", filt[3], 1);
    tally_and_finish();
  end
endmodule
